// ### rtl/pias_pkg.sv
// constants and types shared by the shared i2s / pcm audio port
package pias_pkg;

  // ***********************************************************
  // clock and link figures
  // ***********************************************************
  localparam int SYS_HZ = 20_000_000;
  localparam int I2S_WORD_BITS = 16;
  localparam int SLOT_BITS = 16;
  localparam int SAMPLE_BITS = 13;
  localparam int NUM_CH = 3;
  localparam logic [7:0] LONG_FS_BITS = 8'h03;

  // ***********************************************************
  // register byte offsets
  // ***********************************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DIV = 8'h04;
  localparam logic [7:0] A_SLOT = 8'h08;
  localparam logic [7:0] A_FMT = 8'h0C;
  localparam logic [7:0] A_I2S_TX = 8'h10;
  localparam logic [7:0] A_I2S_RX = 8'h14;
  localparam logic [7:0] A_PCM_TX0 = 8'h18;
  localparam logic [7:0] A_PCM_RX0 = 8'h24;
  localparam logic [7:0] A_STAT = 8'h30;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int C_I2S_EN = 0;
  localparam int C_PCM_EN = 1;
  localparam int C_MASTER = 2;
  localparam int C_LONG_FS = 3;
  localparam int C_BURST = 4;
  localparam int S_CH_SLOT0 = 4;
  localparam int S_CH_EN0 = 16;
  localparam int F_LSB_FIRST = 0;
  localparam int F_SHIFT = 1;
  localparam int F_FILL = 3;
  localparam int F_FILL_VAL = 5;

  // ***********************************************************
  // values after reset
  // ***********************************************************
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [15:0] DIV_RST = 16'h014D;
  localparam logic [18:0] SLOT_RST = 19'h10000;
  localparam logic [7:0] FMT_RST = 8'h00;

  typedef enum logic [1:0] {MODE_OFF, MODE_I2S, MODE_PCM} pias_mode_t;
  typedef enum logic [1:0] {
    FILL_ZERO, FILL_ONE, FILL_SIGN, FILL_VALUE
  } pias_fill_t;

endpackage

// ### rtl/pias_port.sv
// shared i2s / pcm serial audio port with register access
`timescale 1ns/1ps

// What this block does
// - i2s master drives clock, select; data always
// - i2s words sixteen bits, msb first
// - msb one bit after select edge
// - left while select low, right while high
// - send on falling, receiver samples rising
// - one shared port, one mode at once
// - pcm master makes clock and sync
// - three full duplex voice channels in slots
// - up to sixteen slots per frame
// - transmit and receive share channel slot
// - data output released on foreign slots
// - release after falling edge, last bit
// - short or long sync, either role
// - short sync one bit, before slot zero
// - slave short sync seen on falling edge
// - long sync three bits from slot zero
// - thirteen bit sample, placement configurable
// - pad bits ignored in, filled out
// - reset format left justified msb first
// - burst mode raises bit rate
module pias_port (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // bit clock pin
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  // word select / frame sync pin
  input wire logic ws_i,
  output logic ws_o,
  output logic ws_oe_o,
  // serial data
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o
);

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic [1:0] ch_of(input logic [7:0] a,
                                       input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[3:2];
  endfunction

  // lowest numbered enabled channel owning the slot
  function automatic logic [2:0] slot_owner(input logic [3:0] slot,
                                            input logic [18:0] cfg);
    logic [2:0] r;
    r = 3'h0;
    for (int i = pias_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (cfg[pias_pkg::S_CH_EN0 + i] &&
          cfg[pias_pkg::S_CH_SLOT0 + 4 * i +: 4] == slot) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] line_idx(input logic [3:0] b,
                                          input logic lsb_first);
    return lsb_first ? b : ~b;
  endfunction

  // ***********************************************************
  // registers
  // ***********************************************************
  logic [4:0] ctrl;
  logic [15:0] divs;
  logic [18:0] slots;
  logic [7:0] fmt;
  logic [31:0] i2s_tx;
  logic [31:0] i2s_rx;
  logic [12:0] pcm_tx [pias_pkg::NUM_CH];
  logic [12:0] pcm_rx [pias_pkg::NUM_CH];

  wire pcm_tx_hit = addr_i >= pias_pkg::A_PCM_TX0 &&
                    addr_i < pias_pkg::A_PCM_RX0 && addr_i[1:0] == 2'h0;
  wire pcm_rx_hit = addr_i >= pias_pkg::A_PCM_RX0 &&
                    addr_i < pias_pkg::A_STAT && addr_i[1:0] == 2'h0;
  wire [1:0] tx_ch = ch_of(addr_i, pias_pkg::A_PCM_TX0);
  wire [1:0] rx_ch = ch_of(addr_i, pias_pkg::A_PCM_RX0);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl <= pias_pkg::CTRL_RST;
      divs <= pias_pkg::DIV_RST;
      slots <= pias_pkg::SLOT_RST;
      fmt <= pias_pkg::FMT_RST;
      i2s_tx <= 32'h0000_0000;
      for (int i = 0; i < pias_pkg::NUM_CH; i++) begin
        pcm_tx[i] <= 13'h0000;
      end
    end else if (wr_i) begin
      if (addr_i == pias_pkg::A_CTRL) ctrl <= wdata_i[4:0];
      if (addr_i == pias_pkg::A_DIV) divs <= wdata_i[15:0];
      if (addr_i == pias_pkg::A_SLOT) slots <= wdata_i[18:0];
      if (addr_i == pias_pkg::A_FMT) fmt <= wdata_i[7:0];
      if (addr_i == pias_pkg::A_I2S_TX) i2s_tx <= wdata_i;
      if (pcm_tx_hit) pcm_tx[tx_ch] <= wdata_i[12:0];
    end
  end

  // ***********************************************************
  // mode and clocking
  // ***********************************************************
  pias_pkg::pias_mode_t mode;
  pias_pkg::pias_mode_t mode_q;
  // i2s wins if software sets both enables
  assign mode = ctrl[pias_pkg::C_I2S_EN] ? pias_pkg::MODE_I2S :
                ctrl[pias_pkg::C_PCM_EN] ? pias_pkg::MODE_PCM :
                pias_pkg::MODE_OFF;
  wire run = mode == mode_q && mode != pias_pkg::MODE_OFF;
  wire master = ctrl[pias_pkg::C_MASTER];
  wire long_fs = ctrl[pias_pkg::C_LONG_FS];
  // burst needs its own divider; 20 MHz caps the pin at 10 MHz
  wire [7:0] half = ctrl[pias_pkg::C_BURST] ? divs[15:8] : divs[7:0];

  logic [7:0] dcnt;
  logic sck_m;
  wire m_tick = run && master && dcnt >= half;

  always_ff @(posedge clock_i) begin
    mode_q <= srst_i ? pias_pkg::MODE_OFF : mode;
    if (srst_i || !run || !master) begin
      dcnt <= 8'h00;
      sck_m <= 1'b0;
    end else if (m_tick) begin
      dcnt <= 8'h00;
      sck_m <= ~sck_m;
    end else begin
      dcnt <= dcnt + 8'h01;
    end
  end

  // pin inputs: three stages, a level counts once stages 2, 3 agree
  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] s3;
  logic [2:0] lvl;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      s3 <= 3'h0;
      lvl <= 3'h0;
    end else begin
      s1 <= {din_i, ws_i, sck_i};
      s2 <= s1;
      s3 <= s2;
      for (int k = 0; k < 3; k++) begin
        if (s2[k] == s3[k]) lvl[k] <= s3[k];
      end
    end
  end
  wire s_new = s2[0] == s3[0] && s3[0] != lvl[0];
  wire fs_in = lvl[1];
  wire din = lvl[2];
  wire rise_ev = run && (master ? m_tick && !sck_m : s_new && s3[0]);
  wire fall_ev = run && (master ? m_tick && sck_m : s_new && !s3[0]);

  // ***********************************************************
  // frame position and data formatting
  // ***********************************************************
  logic [7:0] pos;
  logic [31:0] acc;
  logic ws_m;
  logic ws_seen;
  logic fs_prev;
  logic dout;
  logic pcm_oe;

  wire [7:0] i2s_next = {3'h0, pos[4:0] + 5'h01};
  wire [4:0] i2s_ahead = i2s_next[4:0] + 5'h01;
  wire [7:0] last = {slots[3:0], 4'hF};
  wire [7:0] pcm_next = pos >= last ? 8'h00 : pos + 8'h01;
  wire [2:0] own_n = slot_owner(pcm_next[7:4], slots);
  wire [2:0] own_c = slot_owner(pos[7:4], slots);
  wire lsb_first = fmt[pias_pkg::F_LSB_FIRST];
  wire [1:0] sh = fmt[pias_pkg::F_SHIFT +: 2];
  wire [1:0] fill = fmt[pias_pkg::F_FILL +: 2];
  wire [2:0] fill_val = fmt[pias_pkg::F_FILL_VAL +: 3];
  wire [12:0] tx_smp = pcm_tx[own_n[1:0]];

  logic [2:0] pad;
  logic [18:0] tx_ext;
  logic [15:0] tx_word;
  logic [4:0] rx_idx;
  logic [31:0] next_acc;
  logic [15:0] rx_al;

  always_comb begin
    unique case (fill)
      pias_pkg::FILL_ZERO: pad = 3'h0;
      pias_pkg::FILL_ONE: pad = 3'h7;
      pias_pkg::FILL_SIGN: pad = {3{tx_smp[12]}};
      pias_pkg::FILL_VALUE: pad = fill_val;
    endcase
    tx_ext = {pad, tx_smp, pad} >> sh;
    tx_word = tx_ext[15:0];
    if (mode == pias_pkg::MODE_I2S) begin
      rx_idx = {pos[4], ~pos[3:0]};
    end else begin
      rx_idx = {1'b0, line_idx(pos[3:0], lsb_first)};
    end
    next_acc = acc;
    next_acc[rx_idx] = din;
    // pad bits fall away here on receive
    rx_al = next_acc[15:0] >> (2'h3 - sh);
  end

  always_ff @(posedge clock_i) begin
    if (srst_i || !run) begin
      pos <= 8'h00;
      acc <= 32'h0000_0000;
      ws_m <= 1'b0;
      ws_seen <= 1'b0;
      fs_prev <= 1'b0;
      dout <= 1'b0;
      pcm_oe <= 1'b0;
    end else if (mode == pias_pkg::MODE_I2S) begin
      if (fall_ev) begin
        pos <= i2s_next;
        dout <= i2s_tx[{i2s_next[4], ~i2s_next[3:0]}];
        ws_m <= i2s_ahead[4];
      end
      if (rise_ev) begin
        acc <= next_acc;
        ws_seen <= fs_in;
        // slave: realign so the next fall sends the msb
        if (!master && fs_in != ws_seen) pos <= {3'h0, ~fs_in, 4'hF};
      end
    end else begin
      if (rise_ev) begin
        pos <= pcm_next;
        ws_m <= long_fs ? pcm_next < pias_pkg::LONG_FS_BITS :
                pcm_next == last;
        pcm_oe <= own_n[2];
        if (own_n[2]) dout <= tx_word[line_idx(pcm_next[3:0], lsb_first)];
      end
      if (fall_ev) begin
        acc <= next_acc;
        fs_prev <= fs_in;
        if (pos[3:0] == 4'hF) pcm_oe <= 1'b0;
        if (!master && !long_fs && fs_in) pos <= last;
        if (!master && long_fs && fs_in && !fs_prev) pos <= 8'h00;
      end
    end
  end

  // received words
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      i2s_rx <= 32'h0000_0000;
      for (int i = 0; i < pias_pkg::NUM_CH; i++) begin
        pcm_rx[i] <= 13'h0000;
      end
    end else if (mode == pias_pkg::MODE_I2S && rise_ev &&
                 pos[3:0] == 4'hF) begin
      i2s_rx <= next_acc;
    end else if (mode == pias_pkg::MODE_PCM && fall_ev &&
                 pos[3:0] == 4'hF && own_c[2]) begin
      pcm_rx[own_c[1:0]] <= rx_al[12:0];
    end
  end

  // ***********************************************************
  // pins and read back
  // ***********************************************************
  assign sck_o = sck_m;
  assign sck_oe_o = run && master;
  assign ws_o = ws_m;
  assign ws_oe_o = run && master;
  assign dout_o = dout;
  assign dout_oe_o = mode_q == pias_pkg::MODE_I2S ||
                     (mode_q == pias_pkg::MODE_PCM && pcm_oe);

  logic [31:0] rd_n;
  always_comb begin
    rd_n = 32'h0000_0000;
    if (addr_i == pias_pkg::A_CTRL) rd_n = {27'h0, ctrl};
    if (addr_i == pias_pkg::A_DIV) rd_n = {16'h0, divs};
    if (addr_i == pias_pkg::A_SLOT) rd_n = {13'h0, slots};
    if (addr_i == pias_pkg::A_FMT) rd_n = {24'h0, fmt};
    if (addr_i == pias_pkg::A_I2S_TX) rd_n = i2s_tx;
    if (addr_i == pias_pkg::A_I2S_RX) rd_n = i2s_rx;
    if (pcm_tx_hit) rd_n = {19'h0, pcm_tx[tx_ch]};
    if (pcm_rx_hit) rd_n = {19'h0, pcm_rx[rx_ch]};
    if (addr_i == pias_pkg::A_STAT) begin
      rd_n = {15'h0, pcm_oe, pos, 6'h0, 2'(mode_q)};
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) rdata_o <= 32'h0000_0000;
    else rdata_o <= rd_i ? rd_n : 32'h0000_0000;
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  chk_off_all_released: assert property (
    mode_q == pias_pkg::MODE_OFF |-> !dout_oe_o && !sck_oe_o && !ws_oe_o)
    else $error("disabled port drives a pin");
  chk_master_drives_pins: assert property (
    run && master |-> sck_oe_o && ws_oe_o)
    else $error("master not driving clock or select");
  chk_slave_takes_clock: assert property (
    !master |-> !sck_oe_o && !ws_oe_o)
    else $error("slave drives clock or select");
  chk_i2s_data_always: assert property (
    mode_q == pias_pkg::MODE_I2S |-> dout_oe_o)
    else $error("i2s data output released");
  chk_i2s_fall_only: assert property (
    mode == pias_pkg::MODE_I2S && $past(run) && $changed(dout_o)
    |-> $past(fall_ev))
    else $error("i2s data changed off a falling edge");
  chk_i2s_select_lead: assert property (
    mode == pias_pkg::MODE_I2S && master && $past(run) && $changed(ws_o)
    |-> pos[3:0] == 4'hF ##[1:520] pos[3:0] == 4'h0)
    else $error("select edge not one bit before msb");
  chk_pcm_last_release: assert property (
    run && mode == pias_pkg::MODE_PCM && fall_ev && pos[3:0] == 4'hF
    |=> !dout_oe_o)
    else $error("pcm output held past last bit");
  chk_pcm_foreign_slot: assert property (
    run && mode == pias_pkg::MODE_PCM && rise_ev && !own_n[2]
    |=> !dout_oe_o)
    else $error("pcm output driven on foreign slot");
  chk_short_sync_pos: assert property (
    run && mode == pias_pkg::MODE_PCM && master && !long_fs && $rose(ws_o)
    |-> pos == last)
    else $error("short sync not in bit before slot zero");
  chk_long_sync_pos: assert property (
    run && mode == pias_pkg::MODE_PCM && master && long_fs && $rose(ws_o)
    |-> pos == 8'h00)
    else $error("long sync not starting at slot zero");

endmodule

// ### tb/pias_codec.sv
// far-end model: clock and sync source, sampling receiver
`timescale 1ns/1ps
module pias_codec (
  // control from the bench
  input wire logic run_i,
  input wire logic pcm_i,
  input wire logic [31:0] tx_i,
  // lines from the port
  input wire logic dout_i,
  input wire logic dout_oe_i,
  // lines to the port
  output logic sck_o,
  output logic ws_o,
  output logic din_o,
  // last captured frame
  output logic [31:0] rx_o,
  output logic [31:0] oe_o
);
  int p;
  initial begin
    sck_o = 1'b1;
    ws_o = 1'b0;
    din_o = 1'b0;
    rx_o = '0;
    oe_o = '0;
    forever begin
      wait (run_i === 1'b1);
      // odd offset keeps pin edges off the system clock
      #13;
      while (run_i === 1'b1) begin
        for (p = 0; p < 32; p++) begin
          #200 sck_o = 1'b0;
          if (pcm_i) begin
            rx_o[31 - p] = dout_i;
            oe_o[31 - p] = dout_oe_i;
          end else begin
            din_o = tx_i[31 - p];
            ws_o = (p >= 15 && p <= 30);
          end
          #200 sck_o = 1'b1;
          if (pcm_i) begin
            ws_o = (p == 30);
            din_o = tx_i[31 - ((p + 1) % 32)];
          end else begin
            rx_o[31 - p] = dout_i;
          end
        end
      end
      // released line must not keep its last value
      din_o = ~din_o;
    end
  end
endmodule

// ### tb/pias_port_tb.sv
// self-checking bench for the shared i2s / pcm audio port
`timescale 1ns/1ps
module pias_port_tb;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic sck_o, sck_oe_o, ws_o, ws_oe_o, dout_o, dout_oe_o;
  logic c_sck, c_ws, c_din;
  logic run = 1'b0;
  logic pcm = 1'b0;
  logic [31:0] ctx = 32'h0;
  logic [31:0] c_rx, c_oe, d, e;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 78;
  wire sck_w = sck_oe_o ? sck_o : c_sck;
  wire ws_w = ws_oe_o ? ws_o : c_ws;

  always #25 clock_i = ~clock_i;

  pias_port u_pias_port (.clock_i(clock_i), .srst_i(srst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .ws_i(ws_w), .ws_o(ws_o), .ws_oe_o(ws_oe_o),
    .din_i(c_din), .dout_o(dout_o), .dout_oe_o(dout_oe_o));

  pias_codec u_pias_codec (.run_i(run), .pcm_i(pcm), .tx_i(ctx),
    .dout_i(dout_o), .dout_oe_i(dout_oe_o), .sck_o(c_sck),
    .ws_o(c_ws), .din_o(c_din), .rx_o(c_rx), .oe_o(c_oe));

  // ****************************************
  // helpers
  // ****************************************
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(posedge clock_i);
    v = rdata_o;
  endtask

  // codec runs whole frames, then the line rests
  task automatic stream(input logic is_pcm);
    pcm <= is_pcm;
    ctx <= $random(seed);
    run <= 1'b1;
    repeat (1300) @(posedge clock_i);
    run <= 1'b0;
    repeat (300) @(posedge clock_i);
  endtask

  task automatic meas(input int hi, input int per);
    int h, l, k;
    h = 0;
    l = 0;
    k = 0;
    while (ws_o !== 1'b0 && k < 999) begin
      @(posedge clock_i);
      k++;
    end
    while (ws_o !== 1'b1 && k < 999) begin
      @(posedge clock_i);
      k++;
    end
    while (ws_o === 1'b1 && h < 999) begin
      @(posedge clock_i);
      h++;
    end
    while (ws_o !== 1'b1 && l < 999) begin
      @(posedge clock_i);
      l++;
    end
    chk("sync width", 32'(hi), 32'(h));
    chk("frame period", 32'(per), 32'(h + l));
  endtask

  function automatic logic [15:0] rev16(input logic [15:0] w);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = w[15 - i];
    return r;
  endfunction

  function automatic logic [15:0] line_word(input logic [7:0] f,
                                            input logic [12:0] s);
    logic [2:0] pad;
    logic [18:0] w;
    case (f[4:3])
      2'h0: pad = 3'h0;
      2'h1: pad = 3'h7;
      2'h2: pad = {3{s[12]}};
      default: pad = f[7:5];
    endcase
    // pad bits ahead of the sample push it towards the lsb end
    w = {pad, s, pad} >> f[2:1];
    return f[0] ? rev16(w[15:0]) : w[15:0];
  endfunction

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] ra [5];
    logic [31:0] rv [5];
    logic [7:0] fm [5];
    logic [7:0] mc [3];
    logic [12:0] s;
    logic [2:0] o;
    int i, bp;
    ra = '{pias_pkg::A_CTRL, pias_pkg::A_DIV, pias_pkg::A_SLOT,
           pias_pkg::A_FMT, 8'h34};
    rv = '{32'(pias_pkg::CTRL_RST), 32'(pias_pkg::DIV_RST),
           32'(pias_pkg::SLOT_RST), 32'(pias_pkg::FMT_RST), 32'h0};
    fm = '{8'h00, 8'h08, 8'h12, 8'hB8, 8'h01};
    mc = '{8'h06, 8'h0E, 8'h16};
    repeat (10) @(posedge clock_i);
    srst_i <= 1'b0;
    // a write into the hole must leave no trace
    wr(8'h34, 32'hFFFFFFFF);
    for (i = 0; i < 5; i++) begin
      rd(ra[i], d);
      chk("reset value", rv[i], d);
    end
    // disabled port ignores a running far end
    o = 3'h0;
    run <= 1'b1;
    repeat (300) begin
      @(posedge clock_i);
      o = o | {sck_oe_o, ws_oe_o, dout_oe_o};
    end
    run <= 1'b0;
    repeat (300) @(posedge clock_i);
    chk("off oe", 32'h0, 32'(o));
    // i2s slave, both directions
    e = $random(seed);
    wr(pias_pkg::A_I2S_TX, e);
    wr(pias_pkg::A_CTRL, 32'h1);
    stream(1'b0);
    chk("i2s oe", 32'h1, {29'h0, sck_oe_o, ws_oe_o, dout_oe_o});
    chk("i2s line", {e[15:0], e[31:16]}, c_rx);
    rd(pias_pkg::A_I2S_RX, d);
    chk("i2s rx", {ctx[15:0], ctx[31:16]}, d);
    wr(pias_pkg::A_CTRL, 32'h3);
    rd(pias_pkg::A_STAT, d);
    chk("mode", 32'h1, 32'(d[1:0]));
    // pcm slave, short sync, ch0 in the second of two slots
    wr(pias_pkg::A_CTRL, 32'h2);
    wr(pias_pkg::A_SLOT, 32'h00010011);
    for (i = 0; i < 5; i++) begin
      s = 13'($random(seed));
      wr(pias_pkg::A_FMT, 32'(fm[i]));
      wr(pias_pkg::A_PCM_TX0, 32'(s));
      stream(1'b1);
      chk("pcm line", 32'(line_word(fm[i], s)), 32'(c_rx[15:0]));
      chk("pcm oe", 32'h0000FFFF, c_oe);
      rd(pias_pkg::A_PCM_RX0, d);
      e = 32'(fm[i][0] ? rev16(ctx[15:0]) : ctx[15:0]);
      chk("pcm rx", 32'(13'(e >> (2'h3 - fm[i][2:1]))), d);
    end
    // pcm master: short, long, burst
    wr(pias_pkg::A_DIV, 32'h00000103);
    wr(pias_pkg::A_SLOT, 32'h00010000);
    for (i = 0; i < 3; i++) begin
      wr(pias_pkg::A_CTRL, 32'(mc[i]));
      chk("master oe", 32'h3, 32'({sck_oe_o, ws_oe_o}));
      bp = 2 * ((mc[i][4] ? 1 : 3) + 1);
      meas(mc[i][3] ? bp * int'(pias_pkg::LONG_FS_BITS) : bp, 16 * bp);
    end
    // i2s master: select low for 16 bits, high for 16 bits
    wr(pias_pkg::A_CTRL, 32'h5);
    meas(16 * 8, 32 * 8);
    stop_test();
  end
endmodule
